// ===== sbm_bank1_map.sv
// bank-one special function register map with avalon-mm slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module sbm_bank1_map #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [sbm_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [sbm_pkg::DATA_W-1:0] avs_writedata_i,
  output logic [sbm_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic pc_increment_i,
  input wire logic pc_load_i,
  input wire logic [7:0] pc_target_low_i,
  input wire logic [sbm_pkg::CORE_FLAG_W-1:0] core_flag_set_i,
  input wire logic [1:0] slave_port_flags_i,
  input wire logic [sbm_pkg::SERIAL_HW_W-1:0] serial_status_i,
  input wire logic tx_shift_empty_i,
  input wire logic [7:0] adc_result_low_i,
  output logic [sbm_pkg::PC_W-1:0] pc_o,
  output logic [7:0] core_status_o,
  output logic [7:0] indirect_pointer_o,
  output logic [7:0] option_config_o,
  output logic [7:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] port_c_direction_o,
  output logic [7:0] port_d_direction_o,
  output logic [7:0] port_e_direction_o,
  output logic [7:0] interrupt_control_o,
  output logic [7:0] peripheral_irq_enable_1_o,
  output logic [7:0] peripheral_irq_enable_2_o,
  output logic [7:0] reset_cause_o,
  output logic [7:0] timer2_period_o,
  output logic [7:0] baud_divisor_o,
  output logic [7:0] adc_config_1_o
);

  typedef enum logic {
    SBM_BUS_IDLE,
    SBM_BUS_ACK
  } sbm_bus_state_t;

  typedef enum logic [1:0] {
    SBM_TGT_NONE,
    SBM_TGT_SFR,
    SBM_TGT_RAM
  } sbm_target_t;

  typedef struct packed {
    sbm_target_t tgt;
    logic [4:0] idx;
  } sbm_hit_t;

  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [sbm_pkg::PC_W-1:0] pc;
    sbm_bus_state_t bus;
    logic waitreq;
    logic [sbm_pkg::DATA_W-1:0] rdata;
  } sbm_state_t;

  sbm_state_t st_q;
  sbm_state_t st_d;
  logic [sbm_pkg::DMEM_ADDR_W-1:0] bus_addr;
  logic [sbm_pkg::DMEM_ADDR_W-1:0] eff_addr;
  sbm_hit_t bus_hit;
  sbm_hit_t hit;
  logic [7:0] sfr_rd;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic [7:0] wm;
  logic ram_we;
  logic [7:0] ram_rdata;

  // short index of a full register offset
  function automatic logic [4:0] sx(input logic [8:0] ofs);
    sx = ofs[4:0];
  endfunction

  // registers mirrored into every bank
  function automatic logic mirrored(input logic [4:0] idx);
    case (idx)
      sx(sbm_pkg::IDX_INDIRECT_DATA_WINDOW),
      sx(sbm_pkg::IDX_PROGRAM_COUNTER_LOW),
      sx(sbm_pkg::IDX_CORE_STATUS),
      sx(sbm_pkg::IDX_INDIRECT_POINTER),
      sx(sbm_pkg::IDX_PROGRAM_COUNTER_HIGH_BUFFER),
      sx(sbm_pkg::IDX_INTERRUPT_CONTROL): mirrored = 1'b1;
      default: mirrored = 1'b0;
    endcase
  endfunction

  // registers that exist only in bank one
  function automatic logic bank_one_only(input logic [4:0] idx);
    case (idx)
      sx(sbm_pkg::IDX_OPTION_CONFIG),
      sx(sbm_pkg::IDX_PORT_A_DIRECTION),
      sx(sbm_pkg::IDX_PORT_B_DIRECTION),
      sx(sbm_pkg::IDX_PORT_C_DIRECTION),
      sx(sbm_pkg::IDX_PERIPHERAL_IRQ_ENABLE_1),
      sx(sbm_pkg::IDX_PERIPHERAL_IRQ_ENABLE_2),
      sx(sbm_pkg::IDX_RESET_CAUSE),
      sx(sbm_pkg::IDX_SERIAL_CONTROL_2),
      sx(sbm_pkg::IDX_TIMER2_PERIOD),
      sx(sbm_pkg::IDX_SERIAL_SLAVE_ADDRESS),
      sx(sbm_pkg::IDX_SERIAL_PORT_STATUS),
      sx(sbm_pkg::IDX_USART_TRANSMIT_CONTROL),
      sx(sbm_pkg::IDX_BAUD_DIVISOR),
      sx(sbm_pkg::IDX_ADC_RESULT_LOW),
      sx(sbm_pkg::IDX_ADC_CONFIG_1): bank_one_only = 1'b1;
      sx(sbm_pkg::IDX_PORT_D_DIRECTION),
      sx(sbm_pkg::IDX_PORT_E_DIRECTION): bank_one_only = !SMALL_PACKAGE;
      default: bank_one_only = 1'b0;
    endcase
  endfunction

  // data address to target; no index holds the counter high byte
  function automatic sbm_hit_t decode(input logic [8:0] a);
    decode.idx = a[4:0];
    if (a[6:0] >= sbm_pkg::GP_RAM_FIRST) begin
      decode.tgt = SBM_TGT_RAM;
    end else if (a[6:5] == 2'b00 && mirrored(a[4:0])) begin
      decode.tgt = SBM_TGT_SFR;
    end else if (a[8:7] == sbm_pkg::BANK_ONE && a[6:5] == 2'b00 &&
                 bank_one_only(a[4:0])) begin
      decode.tgt = SBM_TGT_SFR;
    end else begin
      decode.tgt = SBM_TGT_NONE;
    end
  endfunction

  // power-on and brown-out value of each stored register
  function automatic logic [7:0] reset_value(input logic [4:0] idx);
    case (idx)
      sx(sbm_pkg::IDX_OPTION_CONFIG): reset_value = sbm_pkg::RST_OPTION_CONFIG;
      sx(sbm_pkg::IDX_CORE_STATUS): reset_value = sbm_pkg::RST_CORE_STATUS;
      sx(sbm_pkg::IDX_PORT_A_DIRECTION):
        reset_value = sbm_pkg::RST_PORT_A_DIRECTION;
      sx(sbm_pkg::IDX_PORT_B_DIRECTION),
      sx(sbm_pkg::IDX_PORT_C_DIRECTION),
      sx(sbm_pkg::IDX_PORT_D_DIRECTION):
        reset_value = sbm_pkg::RST_PORT_BCD_DIRECTION;
      sx(sbm_pkg::IDX_PORT_E_DIRECTION):
        reset_value = sbm_pkg::RST_PORT_E_DIRECTION;
      sx(sbm_pkg::IDX_TIMER2_PERIOD): reset_value = sbm_pkg::RST_TIMER2_PERIOD;
      sx(sbm_pkg::IDX_USART_TRANSMIT_CONTROL):
        reset_value = sbm_pkg::RST_USART_TRANSMIT_CONTROL;
      default: reset_value = sbm_pkg::RST_DEFAULT;
    endcase
  endfunction

  // bits that exist; everything else reads zero
  function automatic logic [7:0] read_mask(input logic [4:0] idx);
    case (idx)
      sx(sbm_pkg::IDX_PORT_A_DIRECTION): read_mask = sbm_pkg::RD_MASK_PORT_A;
      sx(sbm_pkg::IDX_PORT_E_DIRECTION): read_mask = sbm_pkg::RD_MASK_PORT_E;
      sx(sbm_pkg::IDX_PROGRAM_COUNTER_HIGH_BUFFER):
        read_mask = sbm_pkg::RD_MASK_PC_HIGH_BUFFER;
      sx(sbm_pkg::IDX_PERIPHERAL_IRQ_ENABLE_2):
        read_mask = sbm_pkg::RD_MASK_IRQ_ENABLE_2;
      sx(sbm_pkg::IDX_RESET_CAUSE): read_mask = sbm_pkg::RD_MASK_RESET_CAUSE;
      sx(sbm_pkg::IDX_USART_TRANSMIT_CONTROL):
        read_mask = sbm_pkg::RD_MASK_USART_TX;
      sx(sbm_pkg::IDX_ADC_CONFIG_1): read_mask = sbm_pkg::RD_MASK_ADC_CONFIG_1;
      default: read_mask = sbm_pkg::MASK_ALL;
    endcase
  endfunction

  // bits software may change; hardware-owned bits are kept out
  function automatic logic [7:0] write_mask(input logic [4:0] idx);
    case (idx)
      sx(sbm_pkg::IDX_CORE_STATUS): write_mask = sbm_pkg::WR_MASK_CORE_STATUS;
      sx(sbm_pkg::IDX_PORT_E_DIRECTION): write_mask = sbm_pkg::WR_MASK_PORT_E;
      sx(sbm_pkg::IDX_SERIAL_PORT_STATUS):
        write_mask = sbm_pkg::WR_MASK_SERIAL_STATUS;
      sx(sbm_pkg::IDX_USART_TRANSMIT_CONTROL):
        write_mask = sbm_pkg::WR_MASK_USART_TX;
      sx(sbm_pkg::IDX_ADC_RESULT_LOW): write_mask = sbm_pkg::MASK_NONE;
      // elsewhere only the readable bits are writable, so reserved bits ignore writes
      default: write_mask = read_mask(idx) & sbm_pkg::MASK_ALL;
    endcase
  endfunction

  // address decode, indirect redirection and read mux
  always_comb begin
    bus_addr = avs_address_i[sbm_pkg::ADDR_W-1:sbm_pkg::WORD_LSB];
    bus_hit = decode(bus_addr);
    eff_addr = bus_addr;
    if (bus_hit.tgt == SBM_TGT_SFR &&
        bus_hit.idx == sx(sbm_pkg::IDX_INDIRECT_DATA_WINDOW)) begin
      eff_addr = {st_q.regs[sx(sbm_pkg::IDX_CORE_STATUS)]
                    [sbm_pkg::STATUS_BANK_SEL_BIT],
                  st_q.regs[sx(sbm_pkg::IDX_INDIRECT_POINTER)]};
    end
    hit = decode(eff_addr);
    // the window pointing at itself has nothing behind it
    if (hit.tgt == SBM_TGT_SFR &&
        hit.idx == sx(sbm_pkg::IDX_INDIRECT_DATA_WINDOW)) begin
      hit.tgt = SBM_TGT_NONE;
    end
    sfr_rd = st_q.regs[hit.idx];
    case (hit.idx)
      sx(sbm_pkg::IDX_PROGRAM_COUNTER_LOW): sfr_rd = st_q.pc[7:0];
      sx(sbm_pkg::IDX_PORT_E_DIRECTION): begin
        sfr_rd[sbm_pkg::PORT_E_IBF_BIT] = slave_port_flags_i[1];
        sfr_rd[sbm_pkg::PORT_E_OBF_BIT] = slave_port_flags_i[0];
      end
      sx(sbm_pkg::IDX_SERIAL_PORT_STATUS):
        sfr_rd[sbm_pkg::SERIAL_HW_W-1:0] = serial_status_i;
      sx(sbm_pkg::IDX_USART_TRANSMIT_CONTROL):
        sfr_rd[sbm_pkg::TX_SHIFT_EMPTY_BIT] = tx_shift_empty_i;
      sx(sbm_pkg::IDX_ADC_RESULT_LOW): sfr_rd = adc_result_low_i;
      default: sfr_rd = st_q.regs[hit.idx];
    endcase
    sfr_rd = sfr_rd & read_mask(hit.idx);
    case (hit.tgt)
      SBM_TGT_SFR: rd_byte = sfr_rd;
      SBM_TGT_RAM: rd_byte = ram_rdata;
      default: rd_byte = 8'h00;
    endcase
    wr_byte = avs_writedata_i[7:0];
    wm = write_mask(hit.idx);
    ram_we = st_q.bus == SBM_BUS_ACK && avs_write_i &&
             hit.tgt == SBM_TGT_RAM;
  end

  // next state: counter, bus handshake, register writes, flags
  always_comb begin
    st_d = st_q;
    // core sequencing; a load takes its upper bits from the buffer
    if (pc_load_i) begin
      st_d.pc = {st_q.regs[sx(sbm_pkg::IDX_PROGRAM_COUNTER_HIGH_BUFFER)]
                   [sbm_pkg::PC_HIGH_W-1:0], pc_target_low_i};
    end else if (pc_increment_i) begin
      st_d.pc = st_q.pc + sbm_pkg::PC_STEP;
    end
    case (st_q.bus)
      SBM_BUS_IDLE: begin
        st_d.waitreq = 1'b1;
        if (avs_read_i || avs_write_i) begin
          st_d.bus = SBM_BUS_ACK;
          st_d.waitreq = 1'b0;
          st_d.rdata = {24'h000000, rd_byte};
        end
      end
      SBM_BUS_ACK: begin
        // write lands on the edge where the master sees waitrequest low
        st_d.bus = SBM_BUS_IDLE;
        st_d.waitreq = 1'b1;
        if (avs_write_i && hit.tgt == SBM_TGT_SFR) begin
          if (hit.idx == sx(sbm_pkg::IDX_PROGRAM_COUNTER_LOW)) begin
            st_d.pc = {st_q.regs[sx(sbm_pkg::IDX_PROGRAM_COUNTER_HIGH_BUFFER)]
                         [sbm_pkg::PC_HIGH_W-1:0], wr_byte};
          end else begin
            st_d.regs[hit.idx] = (st_q.regs[hit.idx] & ~wm) |
                                 (wr_byte & wm);
          end
        end
      end
      default: begin
        st_d.bus = SBM_BUS_IDLE;
        st_d.waitreq = 1'b1;
      end
    endcase
    // hardware flag set wins over a same-cycle software clear
    st_d.regs[sx(sbm_pkg::IDX_INTERRUPT_CONTROL)]
      [sbm_pkg::CORE_FLAG_W-1:0] =
      st_d.regs[sx(sbm_pkg::IDX_INTERRUPT_CONTROL)]
        [sbm_pkg::CORE_FLAG_W-1:0] | core_flag_set_i;
  end

  // the whole state is one register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 32; i++) begin
        st_q.regs[i] <= reset_value(5'(i));
      end
      st_q.pc <= sbm_pkg::RST_PC;
      st_q.bus <= SBM_BUS_IDLE;
      st_q.waitreq <= 1'b1;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  // data memory behind direct and indirect addresses
  sbm_gp_ram #(
    .ADDR_W(sbm_pkg::DMEM_ADDR_W),
    .DATA_W(sbm_pkg::REG_W)
  ) u_ram (
    .core_clk_i(core_clk_i),
    .addr_i(eff_addr),
    .wr_en_i(ram_we),
    .wdata_i(wr_byte),
    .rdata_o(ram_rdata)
  );

  // outputs straight from the state register
  assign avs_readdata_o = st_q.rdata;
  assign avs_waitrequest_o = st_q.waitreq;
  assign pc_o = st_q.pc;
  assign core_status_o = st_q.regs[sx(sbm_pkg::IDX_CORE_STATUS)];
  assign indirect_pointer_o = st_q.regs[sx(sbm_pkg::IDX_INDIRECT_POINTER)];
  assign option_config_o = st_q.regs[sx(sbm_pkg::IDX_OPTION_CONFIG)];
  assign port_a_direction_o = st_q.regs[sx(sbm_pkg::IDX_PORT_A_DIRECTION)];
  assign port_b_direction_o = st_q.regs[sx(sbm_pkg::IDX_PORT_B_DIRECTION)];
  assign port_c_direction_o = st_q.regs[sx(sbm_pkg::IDX_PORT_C_DIRECTION)];
  assign port_d_direction_o = st_q.regs[sx(sbm_pkg::IDX_PORT_D_DIRECTION)];
  assign port_e_direction_o = st_q.regs[sx(sbm_pkg::IDX_PORT_E_DIRECTION)];
  assign interrupt_control_o =
    st_q.regs[sx(sbm_pkg::IDX_INTERRUPT_CONTROL)];
  assign peripheral_irq_enable_1_o =
    st_q.regs[sx(sbm_pkg::IDX_PERIPHERAL_IRQ_ENABLE_1)];
  assign peripheral_irq_enable_2_o =
    st_q.regs[sx(sbm_pkg::IDX_PERIPHERAL_IRQ_ENABLE_2)];
  assign reset_cause_o = st_q.regs[sx(sbm_pkg::IDX_RESET_CAUSE)];
  assign timer2_period_o = st_q.regs[sx(sbm_pkg::IDX_TIMER2_PERIOD)];
  assign baud_divisor_o = st_q.regs[sx(sbm_pkg::IDX_BAUD_DIVISOR)];
  assign adc_config_1_o = st_q.regs[sx(sbm_pkg::IDX_ADC_CONFIG_1)];

endmodule

// ===== sbm_pkg.sv
// constants for the bank-one special function register map
// Overview of operation
// - unimplemented locations and bits read zero, ignore writes
// - program counter high byte has no address
// - five-bit buffer feeds counter bits 12..8 on load
// - core registers answer identically in every bank
// - small package drops port d/e directions, read zero
package sbm_pkg;

  // bus geometry: one register per aligned 32-bit word
  localparam int ADDR_W = 11;
  localparam int DMEM_ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int WORD_LSB = 2;

  // register indices, byte address is four times the index
  localparam logic [8:0] IDX_INDIRECT_DATA_WINDOW = 9'h080;
  localparam logic [8:0] IDX_OPTION_CONFIG = 9'h081;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_LOW = 9'h082;
  localparam logic [8:0] IDX_CORE_STATUS = 9'h083;
  localparam logic [8:0] IDX_INDIRECT_POINTER = 9'h084;
  localparam logic [8:0] IDX_PORT_A_DIRECTION = 9'h085;
  localparam logic [8:0] IDX_PORT_B_DIRECTION = 9'h086;
  localparam logic [8:0] IDX_PORT_C_DIRECTION = 9'h087;
  localparam logic [8:0] IDX_PORT_D_DIRECTION = 9'h088;
  localparam logic [8:0] IDX_PORT_E_DIRECTION = 9'h089;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_HIGH_BUFFER = 9'h08a;
  localparam logic [8:0] IDX_INTERRUPT_CONTROL = 9'h08b;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_1 = 9'h08c;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_2 = 9'h08d;
  localparam logic [8:0] IDX_RESET_CAUSE = 9'h08e;
  localparam logic [8:0] IDX_SERIAL_CONTROL_2 = 9'h091;
  localparam logic [8:0] IDX_TIMER2_PERIOD = 9'h092;
  localparam logic [8:0] IDX_SERIAL_SLAVE_ADDRESS = 9'h093;
  localparam logic [8:0] IDX_SERIAL_PORT_STATUS = 9'h094;
  localparam logic [8:0] IDX_USART_TRANSMIT_CONTROL = 9'h098;
  localparam logic [8:0] IDX_BAUD_DIVISOR = 9'h099;
  localparam logic [8:0] IDX_ADC_RESULT_LOW = 9'h09e;
  localparam logic [8:0] IDX_ADC_CONFIG_1 = 9'h09f;

  // reset values on power-on and brown-out
  localparam logic [7:0] RST_OPTION_CONFIG = 8'hff;
  localparam logic [7:0] RST_CORE_STATUS = 8'h18;
  localparam logic [7:0] RST_PORT_A_DIRECTION = 8'h3f;
  localparam logic [7:0] RST_PORT_BCD_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT_E_DIRECTION = 8'h07;
  localparam logic [7:0] RST_TIMER2_PERIOD = 8'hff;
  localparam logic [7:0] RST_USART_TRANSMIT_CONTROL = 8'h02;
  localparam logic [7:0] RST_DEFAULT = 8'h00;
  localparam logic [12:0] RST_PC = 13'h0000;

  // implemented bits per register
  localparam logic [7:0] RD_MASK_PORT_A = 8'h3f;
  localparam logic [7:0] RD_MASK_PORT_E = 8'hf7;
  localparam logic [7:0] RD_MASK_PC_HIGH_BUFFER = 8'h1f;
  localparam logic [7:0] RD_MASK_IRQ_ENABLE_2 = 8'h59;
  localparam logic [7:0] RD_MASK_RESET_CAUSE = 8'h03;
  localparam logic [7:0] RD_MASK_USART_TX = 8'hf7;
  localparam logic [7:0] RD_MASK_ADC_CONFIG_1 = 8'h8f;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // software-writable bits where hardware owns the rest
  localparam logic [7:0] WR_MASK_CORE_STATUS = 8'he7;
  localparam logic [7:0] WR_MASK_PORT_E = 8'h37;
  localparam logic [7:0] WR_MASK_SERIAL_STATUS = 8'hc0;
  localparam logic [7:0] WR_MASK_USART_TX = 8'hf5;

  // field positions
  localparam int STATUS_BANK_SEL_BIT = 7;
  localparam int PORT_E_IBF_BIT = 7;
  localparam int PORT_E_OBF_BIT = 6;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam int PC_HIGH_W = 5;
  localparam int PC_W = 13;
  localparam int CORE_FLAG_W = 3;
  localparam int SERIAL_HW_W = 6;

  // address space split
  localparam logic [6:0] GP_RAM_FIRST = 7'h20;
  localparam logic [1:0] BANK_ONE = 2'b01;
  localparam logic [12:0] PC_STEP = 13'h0001;

endpackage

// ===== sbm_gp_ram.sv
// general purpose data memory reached directly or through the window
`timescale 1ns/10ps
module sbm_gp_ram #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 8
) (
  input wire logic core_clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o
);

  // plain array, no reset: contents are undefined after power-up
  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  // asynchronous read keeps the bus answer to one cycle
  assign rdata_o = mem_q[addr_i];

  // single write port
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

endmodule

// ===== sbm_bank1_map_chk.sv
// bus handshake, counter and reserved-bit checks for the register map
`timescale 1ns/10ps
module sbm_bank1_map_chk (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [sbm_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [sbm_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic pc_increment_i,
  input wire logic pc_load_i,
  input wire logic [sbm_pkg::PC_W-1:0] pc_o,
  input wire logic [7:0] port_a_direction_o,
  input wire logic [7:0] peripheral_irq_enable_2_o,
  input wire logic [7:0] reset_cause_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic pcl_wr;
  // a bus write to the counter low byte takes effect at its ack edge
  assign pcl_wr = avs_write_i && !avs_waitrequest_o &&
    avs_address_i[8:2] == 7'h02;

  // one cycle after a fresh request the slave must answer
  ack_after_req_a: assert property ($rose(avs_read_i || avs_write_i)
    |=> !avs_waitrequest_o) else $error("no ack one cycle after request");
  ack_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("ack held longer than one cycle");
  ack_needs_req_a: assert property (!avs_waitrequest_o
    |-> $past(avs_read_i || avs_write_i)) else $error("ack without request");
  upper_lanes_zero_a: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  // holes 08f, 090 and 095 in the bank-one map always read zero
  unimpl_read_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[10:2] inside {9'h08f, 9'h090, 9'h095}
    |-> avs_readdata_o == 32'h0) else $error("hole read not zero");
  pc_step_a: assert property (pc_increment_i && !pc_load_i && !pcl_wr
    |=> pc_o == $past(pc_o) + 13'h0001) else $error("counter step wrong");
  // no address but the low byte may move the counter; pcl_wr sees only direct writes, not those through the window
  pc_hold_a: assert property (!pc_increment_i && !pc_load_i && !pcl_wr
    |=> $stable(pc_o)) else $error("counter moved without cause");
  reserved_zero_a: assert property (port_a_direction_o[7:6] == 2'b00 &&
    reset_cause_o[7:2] == 6'h00 && (peripheral_irq_enable_2_o & 8'ha6) == 8'h00)
    else $error("unimplemented bit not zero");
endmodule

// ===== tb_top.sv
// self-checking bench for the bank-one register map
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [sbm_pkg::ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [sbm_pkg::DATA_W-1:0] wdata = '0;
  logic [sbm_pkg::DATA_W-1:0] rdata;
  logic waitreq;
  logic pc_inc = 1'b0;
  logic pc_ld = 1'b0;
  logic [7:0] pc_tgt = 8'h00;
  logic [2:0] flag_set = 3'h0;
  logic [1:0] sp_flags = 2'h0;
  logic [5:0] ser = 6'h00;
  logic tx_empty = 1'b1;
  logic [7:0] adc = 8'h00;
  logic [sbm_pkg::PC_W-1:0] pc;
  logic [sbm_pkg::DATA_W-1:0] rdata_s;
  logic [31:0] rd_small = '0;
  wire [7:0] so [15];
  int miscompares = 0;
  int checked = 0;

  // free-running core clock, 8 ns period
  always #4 clk = ~clk;

  sbm_bank1_map #(.SMALL_PACKAGE(1'b0)) dut (
    .core_clk_i(clk), .resetn_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .pc_increment_i(pc_inc), .pc_load_i(pc_ld), .pc_target_low_i(pc_tgt),
    .core_flag_set_i(flag_set), .slave_port_flags_i(sp_flags),
    .serial_status_i(ser), .tx_shift_empty_i(tx_empty),
    .adc_result_low_i(adc), .pc_o(pc), .core_status_o(so[0]),
    .indirect_pointer_o(so[1]), .option_config_o(so[2]),
    .port_a_direction_o(so[3]), .port_b_direction_o(so[4]),
    .port_c_direction_o(so[5]), .port_d_direction_o(so[6]),
    .port_e_direction_o(so[7]), .interrupt_control_o(so[8]),
    .peripheral_irq_enable_1_o(so[9]), .peripheral_irq_enable_2_o(so[10]),
    .reset_cause_o(so[11]), .timer2_period_o(so[12]),
    .baud_divisor_o(so[13]), .adc_config_1_o(so[14])
  );

  // small package variant sees the same stimulus, read data compared only
  sbm_bank1_map #(.SMALL_PACKAGE(1'b1)) dut_small (
    .core_clk_i(clk), .resetn_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata_s), .avs_waitrequest_o(),
    .pc_increment_i(pc_inc), .pc_load_i(pc_ld), .pc_target_low_i(pc_tgt),
    .core_flag_set_i(flag_set), .slave_port_flags_i(sp_flags),
    .serial_status_i(ser), .tx_shift_empty_i(tx_empty),
    .adc_result_low_i(adc), .pc_o(), .core_status_o(),
    .indirect_pointer_o(), .option_config_o(), .port_a_direction_o(),
    .port_b_direction_o(), .port_c_direction_o(), .port_d_direction_o(),
    .port_e_direction_o(), .interrupt_control_o(),
    .peripheral_irq_enable_1_o(), .peripheral_irq_enable_2_o(),
    .reset_cause_o(), .timer2_period_o(), .baud_divisor_o(),
    .adc_config_1_o()
  );

  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [8:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    rd <= !we;
    wr <= we;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd_small = rdata_s;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      miscompares++;
      print_verdict();
    end
  endtask

  task automatic wr_reg(input logic [8:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [8:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, {24'h0, e});
  endtask

  // one-cycle pulse on the core-side pins, settled at the next low phase
  task automatic pulse(input logic ld, input logic inc, input logic [7:0] t,
                       input logic [2:0] f);
    @(posedge clk);
    pc_ld <= ld;
    pc_inc <= inc;
    pc_tgt <= t;
    flag_set <= f;
    @(posedge clk);
    pc_ld <= 1'b0;
    pc_inc <= 1'b0;
    flag_set <= 3'h0;
    @(negedge clk);
  endtask

  task automatic reset_values();
    logic [8:0] ia [23] = '{9'h080, 9'h081, 9'h082, 9'h083, 9'h084, 9'h085,
      9'h086, 9'h087, 9'h088, 9'h089, 9'h08a, 9'h08b, 9'h08c, 9'h08d, 9'h08e,
      9'h091, 9'h092, 9'h093, 9'h094, 9'h098, 9'h099, 9'h09e, 9'h09f};
    logic [7:0] ea [23] = '{8'h00, 8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff,
      8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
      8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
    logic [7:0] es [15] = '{8'h18, 8'h00, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff,
      8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 23; i++) begin
      rd_chk(ia[i], ea[i]);
    end
    // register outputs must show the same reset values
    for (int i = 0; i < 15; i++) begin
      check({24'h0, so[i]}, {24'h0, es[i]});
    end
  endtask

  // all ones (bf to 08d) written to holes and masked registers, only implemented bits come back
  task automatic masks();
    logic [8:0] ia [13] = '{9'h08f, 9'h090, 9'h095, 9'h09a, 9'h09d, 9'h085,
      9'h08a, 9'h08d, 9'h08e, 9'h098, 9'h09f, 9'h089, 9'h09e};
    logic [7:0] ea [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h1f,
      8'h19, 8'h03, 8'hf7, 8'h8f, 8'h37, 8'h00};
    for (int i = 0; i < 13; i++) begin
      // implemented bit 6 of enable 2 is written zero, so it reads back clear
      wr_reg(ia[i], ia[i] == 9'h08d ? 8'hbf : 8'hff);
      rd_chk(ia[i], ea[i]);
    end
    sp_flags <= 2'h3;
    ser <= 6'h2a;
    adc <= 8'h5c;
    tx_empty <= 1'b0;
    rd_chk(9'h089, 8'hf7);
    rd_chk(9'h094, 8'h2a);
    rd_chk(9'h09e, 8'h5c);
    rd_chk(9'h098, 8'hf5);
  endtask

  // core registers seen through other banks, others stay holes
  task automatic mirror();
    wr_reg(9'h10a, 8'h15);
    rd_chk(9'h18a, 8'h15);
    rd_chk(9'h00a, 8'h15);
    wr_reg(9'h004, 8'h66);
    rd_chk(9'h184, 8'h66);
    rd_chk(9'h084, 8'h66);
    pulse(1'b0, 1'b0, 8'h00, 3'h5);
    rd_chk(9'h10b, 8'h05);
    check({24'h0, so[8]}, 32'h05);
    check({24'h0, so[1]}, 32'h66);
    rd_chk(9'h105, 8'h00);
    rd_chk(9'h188, 8'h00);
  endtask

  // upper counter bits load from the holding buffer; an increment carries into them
  task automatic pc_path();
    wr_reg(9'h08a, 8'h1a);
    pulse(1'b1, 1'b0, 8'h34, 3'h0);
    check(pc, 32'h1a34);
    wr_reg(9'h082, 8'h56);
    @(negedge clk);
    check(pc, 32'h1a56);
    rd_chk(9'h082, 8'h56);
    pulse(1'b0, 1'b1, 8'h00, 3'h0);
    check(pc, 32'h1a57);
    pulse(1'b1, 1'b1, 8'h34, 3'h0);
    check(pc, 32'h1a34);
    wr_reg(9'h08a, 8'hff);
    wr_reg(9'h082, 8'hff);
    @(negedge clk);
    check(pc, 32'h1fff);
    pulse(1'b0, 1'b1, 8'h00, 3'h0);
    check(pc, 32'h0000);
  endtask

  // window redirects to ram or registers; a window pointing at itself is empty
  task automatic indirect();
    wr_reg(9'h084, 8'h40);
    wr_reg(9'h080, 8'ha5);
    rd_chk(9'h040, 8'ha5);
    rd_chk(9'h180, 8'ha5);
    wr_reg(9'h084, 8'h85);
    wr_reg(9'h080, 8'h0c);
    rd_chk(9'h085, 8'h0c);
    wr_reg(9'h084, 8'h80);
    wr_reg(9'h080, 8'h77);
    rd_chk(9'h080, 8'h00);
    // status bit 7 selects the upper half for the window
    wr_reg(9'h083, 8'h80);
    rd_chk(9'h183, 8'h98);
    check({24'h0, so[0]}, 32'h98);
    wr_reg(9'h084, 8'h40);
    wr_reg(9'h080, 8'h3c);
    rd_chk(9'h140, 8'h3c);
    rd_chk(9'h040, 8'ha5);
  endtask

  // small variant: no port d/e directions; parallel slave enable kept clear
  task automatic small_pkg();
    wr_reg(9'h08c, 8'h7f);
    rd_chk(9'h08c, 8'h7f);
    check(rd_small, 32'h7f);
    check({24'h0, so[9]}, 32'h7f);
    wr_reg(9'h088, 8'h5a);
    rd_chk(9'h088, 8'h5a);
    check(rd_small, 32'h0);
    rd_chk(9'h089, 8'hf7);
    check(rd_small, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    masks();
    mirror();
    pc_path();
    indirect();
    small_pkg();
    print_verdict();
  end
endmodule

bind sbm_bank1_map sbm_bank1_map_chk chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pc_increment_i(pc_increment_i),
  .pc_load_i(pc_load_i), .pc_o(pc_o),
  .port_a_direction_o(port_a_direction_o),
  .peripheral_irq_enable_2_o(peripheral_irq_enable_2_o),
  .reset_cause_o(reset_cause_o)
);
